/* File: logic/cfx_core.sv */
// core execution datapath: register file, ALU, status flags, prefetch, irq pick
`timescale 1ns/1ps
module cfx_core #(
    parameter int NUM_IRQ = 8,
    parameter logic [15:0] BOOT_START = 16'hF000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] prog_word,
    input wire logic [NUM_IRQ-1:0] irq_req,
    output logic [15:0] prog_addr,
    output logic [7:0] status_flags,
    output logic [7:0] irq_taken,
    output logic spm_grant,
    output logic spm_denied
);
    // ====================================================
    // state
    cfx_pkg::cfx_state_type state_reg;
    cfx_pkg::cfx_state_type state_next;
    cfx_pkg::cfx_alu_type alu;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [4:0] rd_idx;
    logic [4:0] rr_idx;
    cfx_pkg::cfx_op_type op;
    logic step;
    logic [NUM_IRQ-1:0] irq_live;
    logic irq_any;
    logic [2:0] irq_pick;
    logic [7:0] n_flag;
    logic [8:0] sum;
    logic [15:0] ds_addr;
    logic [15:0] z_ptr;
    logic [7:0] sub_rhs;
    logic [15:0] exec_pc;
    logic [7:0] rf_word [32];

    // ====================================================
    // register file view
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_rf
            assign rf_word[gi] = state_reg.rf[gi*8 +: 8];
        end
    endgenerate

    // ====================================================
    // decode
    always_comb begin
        op = cfx_pkg::cfx_op_type'(state_reg.insn[15:11]);
        imm = state_reg.insn[7:0];
        rr_idx = state_reg.insn[5:1];
        if (op == cfx_pkg::OP_SUBI || op == cfx_pkg::OP_ANDI || op == cfx_pkg::OP_ORI
                || op == cfx_pkg::OP_LDI) begin
            rd_idx = 5'(cfx_pkg::IMM_RD_BASE) + {2'b00, state_reg.insn[10:8]};
        end else begin
            rd_idx = state_reg.insn[10:6];
        end
        rd_val = rf_word[rd_idx];
        rr_val = rf_word[rr_idx];
        z_ptr = {rf_word[cfx_pkg::PTR_Z_LO+1], rf_word[cfx_pkg::PTR_Z_LO]};
        ds_addr = {rf_word[cfx_pkg::PTR_X_LO+1], rf_word[cfx_pkg::PTR_X_LO]};
    end

    // lowest index wins
    always_comb begin
        irq_pick = 3'h0;
        irq_any = 1'b0;
        irq_live = irq_req & {NUM_IRQ{state_reg.status[cfx_pkg::BIT_I]}};
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_live[i]) begin
                irq_pick = 3'(i);
                irq_any = 1'b1;
            end
        end
    end

    // ====================================================
    // ALU
    always_comb begin
        alu = '0;
        sum = 9'h000;
        sub_rhs = (op == cfx_pkg::OP_SUBI) ? imm : rr_val;
        case (op)
            cfx_pkg::OP_ADD, cfx_pkg::OP_ADC: begin
                sum = {1'b0, rd_val} + {1'b0, rr_val}
                    + {8'h00, op == cfx_pkg::OP_ADC && state_reg.status[cfx_pkg::BIT_C]};
                alu.res = sum[7:0];
                alu.c = sum[8];
                alu.h = (rd_val[3] & rr_val[3]) | (rr_val[3] & ~sum[3])
                    | (~sum[3] & rd_val[3]);
                alu.v = (rd_val[7] & rr_val[7] & ~sum[7])
                    | (~rd_val[7] & ~rr_val[7] & sum[7]);
                alu.wr = 1'b1;
                alu.flags = 1'b1;
                alu.hv = 1'b1;
            end
            cfx_pkg::OP_SUB, cfx_pkg::OP_SBC, cfx_pkg::OP_SUBI, cfx_pkg::OP_NEG: begin
                if (op == cfx_pkg::OP_NEG) begin
                    sum = 9'h000 - {1'b0, rd_val};
                    alu.h = sum[3] | rd_val[3];
                    alu.v = (sum[7:0] == 8'h80);
                end else begin
                    sum = {1'b0, rd_val}
                        - {1'b0, sub_rhs}
                        - {8'h00, op == cfx_pkg::OP_SBC && state_reg.status[cfx_pkg::BIT_C]};
                    alu.h = (~rd_val[3] & sub_rhs[3]) | (sub_rhs[3] & sum[3])
                        | (sum[3] & ~rd_val[3]);
                    alu.v = (rd_val[7] & ~sub_rhs[7] & ~sum[7])
                        | (~rd_val[7] & sub_rhs[7] & sum[7]);
                end
                alu.res = sum[7:0];
                alu.c = sum[8];
                alu.wr = 1'b1;
                alu.flags = 1'b1;
                alu.hv = 1'b1;
            end
            cfx_pkg::OP_AND, cfx_pkg::OP_ANDI, cfx_pkg::OP_OR, cfx_pkg::OP_ORI,
            cfx_pkg::OP_EOR: begin
                case (op)
                    cfx_pkg::OP_AND: alu.res = rd_val & rr_val;
                    cfx_pkg::OP_ANDI: alu.res = rd_val & imm;
                    cfx_pkg::OP_OR: alu.res = rd_val | rr_val;
                    cfx_pkg::OP_ORI: alu.res = rd_val | imm;
                    default: alu.res = rd_val ^ rr_val;
                endcase
                alu.c = state_reg.status[cfx_pkg::BIT_C];
                alu.wr = 1'b1;
                alu.flags = 1'b1;
            end
            cfx_pkg::OP_INC, cfx_pkg::OP_DEC: begin
                alu.res = (op == cfx_pkg::OP_INC) ? rd_val + 8'h01 : rd_val - 8'h01;
                alu.v = (op == cfx_pkg::OP_INC) ? (rd_val == 8'h7F) : (rd_val == 8'h80);
                alu.c = state_reg.status[cfx_pkg::BIT_C];
                alu.wr = 1'b1;
                alu.flags = 1'b1;
            end
            cfx_pkg::OP_COM: begin
                alu.res = ~rd_val;
                alu.c = 1'b1;
                alu.wr = 1'b1;
                alu.flags = 1'b1;
            end
            cfx_pkg::OP_LSR: begin
                alu.res = {1'b0, rd_val[7:1]};
                alu.c = rd_val[0];
                alu.v = rd_val[0];
                alu.wr = 1'b1;
                alu.flags = 1'b1;
            end
            cfx_pkg::OP_MOV: begin
                alu.res = rr_val;
                alu.wr = 1'b1;
            end
            cfx_pkg::OP_LDI: begin
                alu.res = imm;
                alu.wr = 1'b1;
            end
            cfx_pkg::OP_BLD: begin
                alu.res = rd_val;
                alu.res[state_reg.insn[2:0]] = state_reg.status[cfx_pkg::BIT_T];
                alu.wr = 1'b1;
            end
            default: alu = '0;
        endcase
    end

    // ====================================================
    // next state
    always_comb begin
        state_next = state_reg;
        n_flag = state_reg.status;
        step = state_reg.ctrl[0] && state_reg.fetch_ok;
        // address the executing instruction was fetched from
        exec_pc = state_reg.pc - cfx_pkg::PIPE_LAG;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.irq_taken = 8'h00;
        // prefetch: word in flight becomes current, next address is fetched
        if (state_reg.ctrl[0]) begin
            state_next.fetch = prog_word;
            state_next.fetch_ok = 1'b1;
            state_next.pc = state_reg.pc + 16'h0001;
        end
        if (step) begin
            state_next.insn = state_reg.fetch;
            if (state_reg.second) begin
                state_next.second = 1'b0;
            end else begin
                if (alu.wr) begin
                    state_next.rf[rd_idx*8 +: 8] = alu.res;
                end
                if (alu.flags) begin
                    n_flag[cfx_pkg::BIT_C] = alu.c;
                    n_flag[cfx_pkg::BIT_Z] = (alu.res == 8'h00);
                    n_flag[cfx_pkg::BIT_N] = alu.res[7];
                    n_flag[cfx_pkg::BIT_V] = alu.v;
                    if (alu.hv) begin
                        n_flag[cfx_pkg::BIT_H] = alu.h;
                    end
                end
                case (op)
                    cfx_pkg::OP_BST: n_flag[cfx_pkg::BIT_T] = rd_val[state_reg.insn[2:0]];
                    cfx_pkg::OP_SEI: n_flag[cfx_pkg::BIT_I] = 1'b1;
                    cfx_pkg::OP_CLI: n_flag[cfx_pkg::BIT_I] = 1'b0;
                    cfx_pkg::OP_INTERRUPT_RETURN_OP: n_flag[cfx_pkg::BIT_I] = 1'b1;
                    cfx_pkg::OP_LONG: state_next.second = 1'b1;
                    cfx_pkg::OP_SPM: begin
                        state_next.spm_ok = (exec_pc >= BOOT_START);
                        state_next.spm_bad = (exec_pc < BOOT_START);
                    end
                    cfx_pkg::OP_IOCHK: begin
                        // direct I/O reaches only 0..0x3F
                        state_next.io_ok = ({2'b00, imm} <= {2'b00, cfx_pkg::IO_LAST});
                        state_next.ext_ok = 1'b0;
                    end
                    cfx_pkg::OP_DSCHK: begin
                        state_next.io_ok = (ds_addr >= cfx_pkg::IO_LO)
                            && (ds_addr <= cfx_pkg::IO_HI);
                        state_next.ext_ok = (ds_addr >= cfx_pkg::EXT_LO)
                            && (ds_addr <= cfx_pkg::EXT_HI);
                    end
                    default: ;
                endcase
                n_flag[cfx_pkg::BIT_S] = n_flag[cfx_pkg::BIT_N] ^ n_flag[cfx_pkg::BIT_V];
            end
            if (irq_any) begin
                state_next.irq_taken[irq_pick] = 1'b1;
                state_next.irq_vec = irq_pick;
                n_flag[cfx_pkg::BIT_I] = 1'b0;
            end
        end
        state_next.status = n_flag;
        // ====================================================
        // APB slave, access phase with one wait state (pready registered)
        if (psel && penable && !state_reg.pready) begin
            state_next.pready = 1'b1;
            state_next.prdata = 32'h0000_0000;
            if (paddr >= cfx_pkg::ADDR_RF_BASE && paddr <= cfx_pkg::ADDR_RF_LAST
                    && paddr[1:0] == 2'b00) begin
                if (pwrite) begin
                    state_next.rf[paddr[6:2]*8 +: 8] = pwdata[7:0];
                end else begin
                    state_next.prdata = {24'h000000, rf_word[paddr[6:2]]};
                end
            end else begin
                case (paddr)
                    cfx_pkg::ADDR_CTRL: begin
                        if (pwrite) begin
                            state_next.ctrl = pwdata;
                        end
                        state_next.prdata = state_reg.ctrl;
                    end
                    cfx_pkg::ADDR_STATUS: begin
                        if (pwrite) begin
                            state_next.status = pwdata[7:0];
                        end
                        state_next.prdata = {24'h000000, state_reg.status};
                    end
                    cfx_pkg::ADDR_INSN: begin
                        if (pwrite) begin
                            state_next.insn = pwdata[15:0];
                            state_next.second = 1'b0;
                        end
                        state_next.prdata = {16'h0000, state_reg.insn};
                    end
                    cfx_pkg::ADDR_PC: begin
                        if (pwrite) begin
                            state_next.pc = pwdata[15:0];
                            state_next.fetch_ok = 1'b0;
                        end
                        state_next.prdata = {16'h0000, state_reg.pc};
                    end
                    cfx_pkg::ADDR_IRQ_PEND: state_next.prdata = {24'h000000, 8'(irq_req)};
                    cfx_pkg::ADDR_IRQ_TAKEN: state_next.prdata = {29'h0, state_reg.irq_vec};
                    cfx_pkg::ADDR_PTR_X: state_next.prdata = {16'h0000, ds_addr};
                    cfx_pkg::ADDR_PTR_Y: state_next.prdata = {16'h0000,
                        rf_word[cfx_pkg::PTR_Y_LO+1], rf_word[cfx_pkg::PTR_Y_LO]};
                    cfx_pkg::ADDR_PTR_Z: state_next.prdata = {16'h0000, z_ptr};
                    cfx_pkg::ADDR_WINDOW: state_next.prdata = {28'h0, state_reg.io_ok,
                        state_reg.ext_ok, state_reg.spm_ok, state_reg.spm_bad};
                    default: state_next.pslverr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.status <= cfx_pkg::STATUS_RESET;
            state_reg.ctrl <= cfx_pkg::CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ====================================================
    // outputs
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign prog_addr = state_reg.pc;
    assign status_flags = state_reg.status;
    assign irq_taken = state_reg.irq_taken;
    assign spm_grant = state_reg.spm_ok;
    assign spm_denied = state_reg.spm_bad;
endmodule // cfx_core

/* File: logic/cfx_pkg.sv */
// constants and carrier types for the core execution datapath
package cfx_pkg;
    // ====================================================
    // register map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_INSN = 12'h008;
    localparam logic [11:0] ADDR_PC = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_PEND = 12'h010;
    localparam logic [11:0] ADDR_IRQ_TAKEN = 12'h014;
    localparam logic [11:0] ADDR_PTR_X = 12'h018;
    localparam logic [11:0] ADDR_PTR_Y = 12'h01C;
    localparam logic [11:0] ADDR_PTR_Z = 12'h020;
    localparam logic [11:0] ADDR_WINDOW = 12'h024;
    localparam logic [11:0] ADDR_RF_BASE = 12'h100;
    localparam logic [11:0] ADDR_RF_LAST = 12'h17C;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ====================================================
    // status bit positions
    localparam int BIT_I = 7;
    localparam int BIT_T = 6;
    localparam int BIT_H = 5;
    localparam int BIT_S = 4;
    localparam int BIT_V = 3;
    localparam int BIT_N = 2;
    localparam int BIT_Z = 1;
    localparam int BIT_C = 0;

    // ====================================================
    // data-space windows
    localparam logic [15:0] IO_LO = 16'h0020;
    localparam logic [15:0] IO_HI = 16'h005F;
    localparam logic [15:0] EXT_LO = 16'h0060;
    localparam logic [15:0] EXT_HI = 16'h00FF;
    localparam logic [5:0] IO_LAST = 6'h3F;
    localparam int PTR_X_LO = 26;
    localparam int PTR_Y_LO = 28;
    localparam int PTR_Z_LO = 30;

    // ====================================================
    // opcode field (insn[15:11]) encodings
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_SBC = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_EOR = 5'h07,
        OP_MOV = 5'h08, OP_SUBI = 5'h09, OP_ANDI = 5'h0A, OP_ORI = 5'h0B,
        OP_LDI = 5'h0C, OP_INC = 5'h0D, OP_DEC = 5'h0E, OP_COM = 5'h0F,
        OP_NEG = 5'h10, OP_LSR = 5'h11, OP_BST = 5'h12, OP_BLD = 5'h13,
        OP_SEI = 5'h14, OP_CLI = 5'h15, OP_INTERRUPT_RETURN_OP = 5'h16, OP_SPM = 5'h17,
        OP_LONG = 5'h18, OP_IOCHK = 5'h19, OP_DSCHK = 5'h1A
    } cfx_op_type;

    // insn: [15:11] op, [10:6] rd, [5:1] rr; immediate = [7:0] with rd in 16..23
    localparam int IMM_RD_BASE = 16;
    // pc runs this far ahead of the executing instruction
    localparam logic [15:0] PIPE_LAG = 16'h0002;

    // ====================================================
    // carriers
    typedef struct packed {
        logic [7:0] res;
        logic h;
        logic v;
        logic c;
        logic wr;
        logic flags;
        logic hv;
    } cfx_alu_type;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] status;
        logic [15:0] insn;
        logic [15:0] fetch;
        logic fetch_ok;
        logic second;
        logic [15:0] pc;
        logic [7:0] irq_taken;
        logic [2:0] irq_vec;
        logic spm_ok;
        logic spm_bad;
        logic io_ok;
        logic ext_ok;
        logic [255:0] rf;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cfx_state_type;
endpackage

/* File: verif/cfx_core_assertions.sv */
// port-level checks for the core execution datapath
`timescale 1ns/1ps
module cfx_core_assertions #(
    parameter int NUM_IRQ = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] prog_word,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] irq_taken,
    input wire logic spm_grant,
    input wire logic spm_denied
);
    // ==========================================
    // assertions
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    reset_clear_a: assert property ($rose(presetn) |-> status_flags == 8'h00)
        else $error("status not clear after reset");
    sign_xor_a: assert property (!$past(psel && penable && pwrite)
        |-> status_flags[4] == (status_flags[2] ^ status_flags[3]))
        else $error("sign flag differs from negative xor overflow");
    irq_gate_a: assert property (irq_taken != 8'h00 |-> $past(status_flags[7]))
        else $error("interrupt taken with global enable clear");
    irq_clear_a: assert property (irq_taken != 8'h00 |-> !status_flags[7])
        else $error("global enable still set after interrupt taken");
    irq_prio_a: assert property (irq_taken != 8'h00
        |-> irq_taken == ($past(irq_req) & (~$past(irq_req) + 8'h01)))
        else $error("interrupt taken is not the lowest pending vector");
    irq_pulse_a: assert property (irq_taken != 8'h00 |=> irq_taken == 8'h00)
        else $error("interrupt taken pulse longer than one cycle");
    fetch_step_a: assert property (prog_addr != $past(prog_addr) && !$past(psel)
        |-> prog_addr == $past(prog_addr) + 16'h0001)
        else $error("fetch address did not step by one");
    spm_excl_a: assert property (!(spm_grant && spm_denied))
        else $error("self-write both granted and refused");
    apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("access phase answer not one cycle");
endmodule // cfx_core_assertions

bind cfx_core cfx_core_assertions #(.NUM_IRQ(NUM_IRQ)) chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_word(prog_word),
    .irq_req(irq_req), .prog_addr(prog_addr), .status_flags(status_flags),
    .irq_taken(irq_taken), .spm_grant(spm_grant), .spm_denied(spm_denied));

/* File: verif/cfx_prog_mem.sv */
// program memory model feeding the fetch port
`timescale 1ns/1ps
module cfx_prog_mem (
    input wire logic [15:0] prog_addr,
    output logic [15:0] prog_word
);
    logic [15:0] words [0:255];

    initial begin
        for (int i = 0; i < 256; i++) begin
            words[i] = 16'h0000;
        end
    end
    // one 16-bit word per location, answered at once
    assign prog_word = words[prog_addr[7:0]];
endmodule // cfx_prog_mem

/* File: verif/cpu_core_alu_status_flags_tb_top.sv */
// self-checking bench for the core execution datapath
`timescale 1ns/1ps
module cpu_core_alu_status_flags_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] irq_req = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] prog_word;
    logic [15:0] prog_addr;
    logic [7:0] status_flags;
    logic [7:0] irq_taken;
    logic spm_grant;
    logic spm_denied;
    int err_total = 0;
    int n_tests = 0;
    int pulses;
    logic [7:0] last_taken;

    always #50 pclk = ~pclk;

    cfx_core #(.NUM_IRQ(8), .BOOT_START(16'h00C0)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_word(prog_word),
        .irq_req(irq_req), .prog_addr(prog_addr), .status_flags(status_flags),
        .irq_taken(irq_taken), .spm_grant(spm_grant), .spm_denied(spm_denied));
    cfx_prog_mem mem (.prog_addr(prog_addr), .prog_word(prog_word));

    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, exp, q);
    endtask

    task automatic load(input int base, input logic [15:0] w [8]);
        for (int i = 0; i < 8; i++) begin
            mem.words[base + i] = w[i];
        end
    endtask

    // start at a program address, run 20 cycles, stop; counts interrupt pulses
    task automatic run_at(input logic [15:0] pc);
        pulses = 0;
        last_taken = 8'h00;
        wr(cfx_pkg::ADDR_PC, {16'h0000, pc});
        wr(cfx_pkg::ADDR_CTRL, 32'h0000_0001);
        repeat (20) begin
            @(posedge pclk);
            if (irq_taken !== 8'h00) begin
                pulses++;
                last_taken = irq_taken;
            end
        end
        wr(cfx_pkg::ADDR_CTRL, 32'h0000_0000);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk("status port", 32'h0, {24'h0, status_flags});
        rd_chk("status reg", cfx_pkg::ADDR_STATUS, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic e;
        wr(12'h114, 32'h0000_005A);
        rd_chk("rf5", 12'h114, 32'h0000_005A);
        apb(1'b0, 12'h0FC, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test regs done");
    endtask

    task automatic t_add();
        run_at(16'h0000);
        chk("fetch addr", 32'h0000_0018, {16'h0000, prog_addr});
        rd_chk("add result", 12'h140, 32'h0000_0080);
        rd_chk("add flags", cfx_pkg::ADDR_STATUS, 32'h0000_002C);
        $display("test add done");
    endtask

    task automatic t_sub();
        run_at(16'h0040);
        rd_chk("subi result", 12'h148, 32'h0000_00FF);
        rd_chk("zero result", 12'h14C, 32'h0000_0000);
        rd_chk("zero flags", cfx_pkg::ADDR_STATUS, 32'h0000_001B);
        $display("test sub done");
    endtask

    task automatic t_irq();
        irq_req <= 8'h24;
        run_at(16'h0060);
        irq_req <= 8'h00;
        chk("irq pulses", 32'h2, pulses);
        chk("irq vector", 32'h4, {24'h0, last_taken});
        rd_chk("irq flags", cfx_pkg::ADDR_STATUS, 32'h0000_005B);
        rd_chk("irq last", cfx_pkg::ADDR_IRQ_TAKEN, 32'h0000_0002);
        $display("test irq done");
    endtask

    task automatic t_spm();
        run_at(16'h0080);
        chk("spm app", 32'h1, {30'h0, spm_grant, spm_denied});
        rd_chk("window app", cfx_pkg::ADDR_WINDOW, 32'h1);
        run_at(16'h00C0);
        chk("spm boot", 32'h2, {30'h0, spm_grant, spm_denied});
        rd_chk("window boot", cfx_pkg::ADDR_WINDOW, 32'hA);
        $display("test spm done");
    endtask

    // pointer window check, bit load from T, skipped second word of a long op
    task automatic t_window();
        wr(12'h168, 32'h0000_0080);
        run_at(16'h00E0);
        rd_chk("ptr x", cfx_pkg::ADDR_PTR_X, 32'h0000_0080);
        rd_chk("window ds", cfx_pkg::ADDR_WINDOW, 32'h6);
        rd_chk("bit load", 12'h150, 32'h0000_0001);
        $display("test window done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        load(8'h00, '{16'h607F, 16'h6101, 16'h0C22, 0, 0, 0, 0, 0});
        load(8'h40, '{16'h6200, 16'h4A01, 16'h6380, 16'h0CE6, 0, 0, 0, 0});
        load(8'h60, '{0, 0, 0, 16'h9407, 16'hA000, 0, 0, 16'hB000});
        load(8'h80, '{16'hB800, 16'hC840, 0, 0, 0, 0, 0, 0});
        load(8'hC0, '{16'hB800, 16'hC83F, 0, 0, 0, 0, 0, 0});
        load(8'hE0, '{16'hD000, 16'h9D00, 16'hC000, 16'h64EE, 0, 0, 0, 0});
        t_reset();
        t_regs();
        t_add();
        t_sub();
        t_irq();
        t_spm();
        t_window();
        wrap_up();
    end
endmodule // cpu_core_alu_status_flags_tb_top
